//--- verilog/uplc_pkg.sv
// Package with constants and pin bundle for the UART pin-level control block
// Functional notes
// - Bus-mode high: read strobe input is an active-low read strobe.
// - Bus-mode high or open: write strobe input is an active-low write strobe.
// - Bus-mode low: direction input high means read, low means write.
// - Power-save request high enters low power at once, isolating the bus.
// - Low power lasts while the request stays high.
// - Release of the power-save request resets every register except rx_to_core, the synchroniser and the wake detect.
// - Master reset is active high in bus-mode high, active low otherwise.
// - Ring indicate rising raises an interrupt when modem status irq enabled.
// - Ring indicate state reads back at modem control bit 6.
// - Modem control bit 1 set drives request-to-send low.
// - Request-to-send is high after any reset.
// - Transmit pin is high in reset, idle or transmitter disabled.
// - Loopback ignores the receive pin and feeds transmit data inside.
// - Loopback disables the transmit pin while data reaches the receiver.
// - Bus-mode high: bit 5 set drives interrupt actively, clear open-source.
// - Bus-mode low: interrupt is active-low open-drain.
// - Chip select high makes the device ignore bus cycles.
package uplc_pkg;

    localparam logic [2:0] UPLC_ADDR_MCR     = 3'h4;
    localparam int         UPLC_MCR_RTS      = 1;
    localparam int         UPLC_MCR_LOOP     = 4;
    localparam int         UPLC_MCR_IRQ_DRV  = 5;
    localparam int         UPLC_MCR_RING     = 6;
    localparam logic [7:0] UPLC_MCR_RESET    = 8'h00;
    localparam logic [7:0] UPLC_MCR_WMASK    = 8'hBF;
    localparam logic [7:0] UPLC_RDATA_NONE   = 8'h00;

    // Sampled pin bundle, one synchroniser for all of it
    typedef struct packed {
        logic       mode_sel;
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] data;
        logic       power_save;
        logic       mreset;
        logic       ring_n;
        logic       rx;
    } uplc_pins_t;

    localparam int UPLC_PINS_W = $bits(uplc_pins_t);

    // Idle pin levels, so reset never looks like an access
    localparam uplc_pins_t UPLC_PINS_IDLE = '{
        mode_sel: 1'b1, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        addr: 3'h0, data: 8'h00, power_save: 1'b0, mreset: 1'b0,
        ring_n: 1'b1, rx: 1'b1};

endpackage : uplc_pkg

//--- verilog/uplc_sync.sv
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/1ps
`default_nettype none
module uplc_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic [W-1:0]   d,
    output var  logic [W-1:0]   q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    if (W < 1) begin : g_chk
        $error("uplc_sync: width must be at least 1");
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // First stage feeds only the second; output moves on agreement
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                q[i] <= RST_VAL[i];
            end else if (s2_q[i] == s3_q[i]) begin
                q[i] <= s3_q[i];
            end
        end
    end

endmodule : uplc_sync
`default_nettype wire

//--- verilog/uplc_top.sv
// Host strobe decode, power save, modem pins and serial line levels
`timescale 1ns/1ps
`default_nettype none
module uplc_top (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       bus_mode_sel,
    input  wire logic       chip_select_n,
    input  wire logic       host_read_strobe_n,
    input  wire logic       host_write_strobe_n,
    input  wire logic [2:0] host_addr,
    input  wire logic [7:0] host_data_in,
    output var  logic [7:0] host_data_out,
    output logic            host_data_oe,
    input  wire logic       master_reset_pin,
    input  wire logic       power_save_request,
    output logic            osc_stop,
    output logic            core_reset,
    input  wire logic       ring_indicate_n,
    input  wire logic       modem_status_irq_en,
    output logic            irq_out,
    output logic            irq_oe,
    output var  logic       rts_n,
    input  wire logic       tx_serial_in,
    input  wire logic       tx_enable,
    output var  logic       tx_pin,
    input  wire logic       rx_pin,
    output var  logic       rx_to_core
);

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} uplc_state_t;

    uplc_pkg::uplc_pins_t raw;
    uplc_pkg::uplc_pins_t pin;
    uplc_state_t          st_q;
    logic [7:0]           mcr_q;
    logic [7:0]           wdata_q;
    logic [2:0]           waddr_q;
    logic                 lp_prev_q;
    logic                 wake_rst_q;
    logic                 ring_prev_q;
    logic                 ring_flag_q;
    logic                 mr_active;
    logic                 bus_ok;
    logic                 read_req;
    logic                 write_req;
    logic                 ring_rise;
    logic                 mcr_read;
    logic                 loop_en;

    always_comb begin
        raw.mode_sel   = bus_mode_sel;
        raw.cs_n       = chip_select_n;
        raw.rd_n       = host_read_strobe_n;
        raw.wr_n       = host_write_strobe_n;
        raw.addr       = host_addr;
        raw.data       = host_data_in;
        raw.power_save = power_save_request;
        raw.mreset     = master_reset_pin;
        raw.ring_n     = ring_indicate_n;
        raw.rx         = rx_pin;
    end

    uplc_sync #(
        .W       (uplc_pkg::UPLC_PINS_W),
        .RST_VAL (uplc_pkg::UPLC_PINS_IDLE)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (raw),
        .q       (pin)
    );

    assign mr_active  = pin.mode_sel ? pin.mreset : !pin.mreset;
    assign core_reset = rst || mr_active || wake_rst_q;
    assign osc_stop   = pin.power_save;
    assign loop_en    = mcr_q[uplc_pkg::UPLC_MCR_LOOP];

    // Low power isolates the bus; chip select gates every cycle
    assign bus_ok    = !pin.cs_n && !pin.power_save;
    // Read has priority if a host drives both strobes at once
    assign read_req  = bus_ok && (pin.mode_sel ? !pin.rd_n
                                               : pin.wr_n);
    assign write_req = bus_ok && !read_req
                       && (pin.mode_sel ? !pin.wr_n
                                        : !pin.wr_n);
    assign mcr_read  = st_q == ST_IDLE && read_req
                       && pin.addr == uplc_pkg::UPLC_ADDR_MCR;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lp_prev_q  <= 1'b0;
            wake_rst_q <= 1'b0;
        end else begin
            lp_prev_q  <= pin.power_save;
            wake_rst_q <= lp_prev_q && !pin.power_save;
        end
    end

    // Write data settle during the strobe, so commit at its end
    always_ff @(posedge clk_sys) begin
        if (core_reset) begin
            st_q    <= ST_IDLE;
            wdata_q <= 8'h00;
            waddr_q <= 3'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (read_req) begin
                        st_q <= ST_RD;
                    end else if (write_req) begin
                        st_q <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (!read_req) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_WR: begin
                    wdata_q <= pin.data;
                    waddr_q <= pin.addr;
                    if (!write_req) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_reset) begin
            mcr_q <= uplc_pkg::UPLC_MCR_RESET;
        end else if (st_q == ST_WR && !write_req
                     && waddr_q == uplc_pkg::UPLC_ADDR_MCR) begin
            mcr_q <= wdata_q & uplc_pkg::UPLC_MCR_WMASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_reset) begin
            host_data_out <= uplc_pkg::UPLC_RDATA_NONE;
        end else if (mcr_read) begin
            host_data_out <= mcr_q & uplc_pkg::UPLC_MCR_WMASK;
            host_data_out[uplc_pkg::UPLC_MCR_RING] <= !pin.ring_n;
        end else if (st_q == ST_IDLE && read_req) begin
            host_data_out <= uplc_pkg::UPLC_RDATA_NONE;
        end
    end

    assign host_data_oe = st_q == ST_RD && read_req;

    // Ringing is low on the pin; the event is its return high
    assign ring_rise = pin.ring_n && !ring_prev_q;

    always_ff @(posedge clk_sys) begin
        if (core_reset) begin
            ring_prev_q <= 1'b1;
            ring_flag_q <= 1'b0;
        end else begin
            ring_prev_q <= pin.ring_n;
            if (ring_rise && modem_status_irq_en) begin
                ring_flag_q <= 1'b1;
            end else if (mcr_read) begin
                ring_flag_q <= 1'b0;
            end
        end
    end

    always_comb begin
        if (!pin.mode_sel) begin
            irq_out = 1'b0;
            irq_oe  = ring_flag_q;
        end else if (mcr_q[uplc_pkg::UPLC_MCR_IRQ_DRV]) begin
            irq_out = ring_flag_q;
            irq_oe  = 1'b1;
        end else begin
            irq_out = 1'b1;
            irq_oe  = ring_flag_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_reset) begin
            rts_n <= 1'b1;
        end else begin
            rts_n <= !mcr_q[uplc_pkg::UPLC_MCR_RTS];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_reset || loop_en || !tx_enable) begin
            tx_pin <= 1'b1;
        end else begin
            tx_pin <= tx_serial_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_to_core <= 1'b1;
        end else begin
            rx_to_core <= loop_en ? tx_serial_in : pin.rx;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_wake;
        pin.power_save ##1 !pin.power_save;
    endsequence

    sequence s_mcr_write_end;
        st_q == ST_WR && !write_req && !core_reset
        && waddr_q == uplc_pkg::UPLC_ADDR_MCR;
    endsequence

    property p_rd_strobe;
        st_q == ST_IDLE && !core_reset && pin.mode_sel && bus_ok
        && !pin.rd_n |=> st_q == ST_RD;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe not taken");

    property p_wr_commit;
        s_mcr_write_end |=> st_q == ST_IDLE
            && mcr_q == ($past(wdata_q) & uplc_pkg::UPLC_MCR_WMASK);
    endproperty
    a_wr_commit: assert property (p_wr_commit)
        else $error("write not committed at strobe end");

    property p_rw_dir;
        st_q == ST_IDLE && !core_reset && !pin.mode_sel && bus_ok
        |=> st_q == (($past(pin.wr_n)) ? ST_RD : ST_WR);
    endproperty
    a_rw_dir: assert property (p_rw_dir)
        else $error("direction input decoded wrongly");

    property p_lp_iso;
        pin.power_save |-> osc_stop && !host_data_oe && !bus_ok;
    endproperty
    a_lp_iso: assert property (p_lp_iso)
        else $error("bus not isolated in low power");

    property p_lp_hold;
        pin.power_save && st_q == ST_IDLE |=> st_q == ST_IDLE;
    endproperty
    a_lp_hold: assert property (p_lp_hold)
        else $error("access taken in low power");

    property p_wake_rst;
        s_wake |-> ##2 mcr_q == uplc_pkg::UPLC_MCR_RESET && rts_n;
    endproperty
    a_wake_rst: assert property (p_wake_rst)
        else $error("no reset after power save release");

    property p_mr_pol;
        (pin.mode_sel ? pin.mreset : !pin.mreset)
        |=> mcr_q == uplc_pkg::UPLC_MCR_RESET && rts_n;
    endproperty
    a_mr_pol: assert property (p_mr_pol)
        else $error("master reset polarity wrong");

    property p_ring_irq;
        ring_rise && modem_status_irq_en && !core_reset
        |=> ring_flag_q ##0 irq_oe;
    endproperty
    a_ring_irq: assert property (p_ring_irq)
        else $error("ring event lost");

    property p_ring_read;
        mcr_read && !core_reset |=>
            host_data_out[uplc_pkg::UPLC_MCR_RING] == !$past(pin.ring_n);
    endproperty
    a_ring_read: assert property (p_ring_read)
        else $error("ring state not read back");

    property p_rts;
        !core_reset && mcr_q[uplc_pkg::UPLC_MCR_RTS] && !$past(core_reset)
        |=> !rts_n;
    endproperty
    a_rts: assert property (p_rts)
        else $error("request to send not driven low");

    property p_rts_rst;
        core_reset |=> rts_n [*1];
    endproperty
    a_rts_rst: assert property (p_rts_rst)
        else $error("request to send low after reset");

    property p_tx_idle;
        core_reset || loop_en || !tx_enable |=> tx_pin;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("transmit pin not idle high");

    property p_loop_rx;
        loop_en |=> rx_to_core == $past(tx_serial_in);
    endproperty
    a_loop_rx: assert property (p_loop_rx)
        else $error("loopback path broken");

    property p_irq_od;
        !pin.mode_sel |-> !irq_out && (irq_oe == ring_flag_q);
    endproperty
    a_irq_od: assert property (p_irq_od)
        else $error("interrupt not open drain active low");

    property p_cs_ignore;
        pin.cs_n && st_q == ST_IDLE |=> st_q == ST_IDLE;
    endproperty
    a_cs_ignore: assert property (p_cs_ignore)
        else $error("access taken without chip select");

endmodule : uplc_top
`default_nettype wire

//--- verif/uplc_modem_model.sv
// Behavioural modem: ring indicate and a serial line sending frames
`timescale 1ns/1ps
`default_nettype none
module uplc_modem_model (
    input  wire logic       clk_sys,
    input  wire logic       ring_req,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    output var  logic       ring_indicate_n,
    output var  logic       rx_line
);
    logic [9:0] frame_q = 10'h3FF;
    logic [3:0] bits_q  = 4'h0;
    logic [2:0] sub_q   = 3'h0;
    logic       busy_q  = 1'b0;

    always_comb ring_indicate_n = ~ring_req;
    always_comb rx_line = busy_q ? frame_q[0] : 1'b1;

    // Eight clocks a bit, so any pin synchroniser delay stays inside a bit
    always_ff @(posedge clk_sys) begin
        if (!busy_q && send) begin
            frame_q <= {1'b1, send_byte, 1'b0};
            busy_q  <= 1'b1;
            bits_q  <= 4'h0;
            sub_q   <= 3'h0;
        end else if (busy_q) begin
            sub_q <= sub_q + 3'h1;
            if (sub_q == 3'h7) begin
                frame_q <= {1'b1, frame_q[9:1]};
                bits_q  <= bits_q + 4'h1;
                busy_q  <= (bits_q != 4'h9);
            end
        end
    end
endmodule : uplc_modem_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the UART pin-level control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    logic       mode    = 1'b1;
    logic       cs_n    = 1'b1;
    logic       rd_n    = 1'b1;
    logic       wr_n    = 1'b1;
    logic [2:0] addr    = 3'h0;
    logic [7:0] din     = 8'h00;
    logic       mrst    = 1'b0;
    logic       psave   = 1'b0;
    logic       irq_en  = 1'b0;
    logic       txd     = 1'b0;
    logic       tx_en   = 1'b1;
    logic       ring_q  = 1'b0;
    logic       send    = 1'b0;
    logic [7:0] sbyte   = 8'h00;
    logic [7:0] dout, rnd, mcr_m, q;
    logic       oe, osc_stop, core_reset, irq_out, irq_oe, rts_n, tx_pin;
    logic       rx_core, ring_n, rx_line, ring_m, g, prev;
    logic       exp_bits[$];
    int         err_count, check_count, cyc, i, k;

    uplc_top u_uplc_top (.clk_sys(clk_sys), .rst(rst), .bus_mode_sel(mode),
        .chip_select_n(cs_n), .host_read_strobe_n(rd_n),
        .host_write_strobe_n(wr_n), .host_addr(addr), .host_data_in(din),
        .host_data_out(dout), .host_data_oe(oe), .master_reset_pin(mrst),
        .power_save_request(psave), .osc_stop(osc_stop),
        .core_reset(core_reset), .ring_indicate_n(ring_n),
        .modem_status_irq_en(irq_en), .irq_out(irq_out), .irq_oe(irq_oe),
        .rts_n(rts_n), .tx_serial_in(txd), .tx_enable(tx_en),
        .tx_pin(tx_pin), .rx_pin(rx_line), .rx_to_core(rx_core));
    uplc_modem_model u_uplc_modem_model (.clk_sys(clk_sys),
        .ring_req(ring_q), .send(send), .send_byte(sbyte),
        .ring_indicate_n(ring_n), .rx_line(rx_line));

    always #4 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    task close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    function automatic logic [7:0] exp_mcr();
        return (mcr_m & uplc_pkg::UPLC_MCR_WMASK) |
               (8'({ring_m}) << uplc_pkg::UPLC_MCR_RING);
    endfunction : exp_mcr

    // Expected interrupt pin value and enable for a given flag state
    function automatic logic [1:0] exp_irq(logic f);
        if (!mode)
            return {1'b0, f};
        return mcr_m[uplc_pkg::UPLC_MCR_IRQ_DRV] ? {f, 1'b1} : {1'b1, f};
    endfunction : exp_irq

    task tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // One host access; sel low keeps chip select inactive
    task acc(input logic w, input logic [2:0] a, input logic [7:0] d,
             input logic sel);
        q = 8'h00;
        g = 1'b0;
        addr = a;
        din = d;
        if (mode) begin
            cs_n = !sel;
            rd_n = w;
            wr_n = !w;
        end else begin
            wr_n = !w;
            tick(1);
            cs_n = !sel;
        end
        for (int j = 0; j < 8; j++) begin
            tick(1);
            if (!w && !g && oe === 1'b1) begin
                g = 1'b1;
                q = dout;
            end
        end
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        tick(8);
    endtask : acc

    task wr_mcr(input logic [7:0] d);
        acc(1'b1, uplc_pkg::UPLC_ADDR_MCR, d, 1'b1);
        mcr_m = d;
    endtask : wr_mcr

    task rd_chk(input logic [2:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00, 1'b1);
        `CHK(g, 1'b1)
        `CHK(q, e)
    endtask : rd_chk

    task set_mode(input logic m);
        mode = m;
        mrst = !m;
        tick(8);
    endtask : set_mode

    // Drives random serial data and checks the transmit pin, and in loopback also the receive path, a cycle later
    task stream(input logic lb);
        prev = txd;
        for (int j = 0; j < 24; j++) begin
            tick(1);
            if (lb) begin
                `CHK(rx_core, prev)
                `CHK(tx_pin, 1'b1)
            end else begin
                `CHK(tx_pin, prev)
            end
            rnd = lfsr(rnd);
            txd = rnd[0];
            prev = txd;
        end
    endtask : stream

    initial begin
        rnd = 8'h28;
        mcr_m = uplc_pkg::UPLC_MCR_RESET;
        ring_m = 1'b0;
        tick(9);
        `CHK({rts_n, tx_pin, rx_core, oe, core_reset}, 5'h1D)
        tick(1);
        rst = 1'b0;
        tick(8);
        `CHK(core_reset, 1'b0)
        for (i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            wr_mcr(rnd & 8'hEF);
            `CHK(rts_n, !mcr_m[uplc_pkg::UPLC_MCR_RTS])
            rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
            acc(1'b1, 3'h7, ~rnd, 1'b1);
            rd_chk(3'h7, uplc_pkg::UPLC_RDATA_NONE);
        end
        acc(1'b1, uplc_pkg::UPLC_ADDR_MCR, ~mcr_m, 1'b0);
        acc(1'b0, uplc_pkg::UPLC_ADDR_MCR, 8'h00, 1'b0);
        `CHK(g, 1'b0)
        rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
        set_mode(1'b0);
        wr_mcr(8'h02);
        `CHK(rts_n, 1'b0)
        rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
        set_mode(1'b1);
        for (k = 0; k < 2; k++) begin
            set_mode(k == 0);
            wr_mcr(8'h02);
            mrst = mode;
            tick(8);
            `CHK(core_reset, 1'b1)
            mrst = !mode;
            tick(8);
            mcr_m = uplc_pkg::UPLC_MCR_RESET;
            `CHK(rts_n, 1'b1)
            rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
        end
        set_mode(1'b1);
        wr_mcr(8'h02);
        psave = 1'b1;
        tick(6);
        `CHK(osc_stop, 1'b1)
        acc(1'b0, uplc_pkg::UPLC_ADDR_MCR, 8'h00, 1'b1);
        `CHK({g, osc_stop}, 2'h1)
        psave = 1'b0;
        tick(8);
        mcr_m = uplc_pkg::UPLC_MCR_RESET;
        `CHK({osc_stop, rts_n}, 2'h1)
        rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
        for (k = 0; k < 3; k++) begin
            set_mode(k < 2);
            wr_mcr((k == 0) ? 8'h20 : 8'h00);
            irq_en = 1'b1;
            ring_q = 1'b1;
            ring_m = 1'b1;
            tick(8);
            `CHK({irq_out, irq_oe}, exp_irq(1'b0))
            rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
            ring_q = 1'b0;
            ring_m = 1'b0;
            tick(8);
            `CHK({irq_out, irq_oe}, exp_irq(1'b1))
            rd_chk(uplc_pkg::UPLC_ADDR_MCR, exp_mcr());
            `CHK({irq_out, irq_oe}, exp_irq(1'b0))
            irq_en = 1'b0;
            ring_q = 1'b1;
            tick(8);
            ring_q = 1'b0;
            tick(8);
            `CHK({irq_out, irq_oe}, exp_irq(1'b0))
        end
        set_mode(1'b1);
        stream(1'b0);
        tx_en = 1'b0;
        txd = 1'b0;
        tick(3);
        `CHK(tx_pin, 1'b1)
        tx_en = 1'b1;
        wr_mcr(8'h10);
        sbyte = 8'h00;
        send = 1'b1;
        tick(1);
        send = 1'b0;
        stream(1'b1);
        wr_mcr(8'h00);
        tick(80);
        rnd = lfsr(rnd);
        sbyte = rnd;
        // Expected line bits, start bit first and data LSB first
        exp_bits.push_back(1'b0);
        for (i = 0; i < 8; i++) begin
            exp_bits.push_back(sbyte[i]);
        end
        exp_bits.push_back(1'b1);
        send = 1'b1;
        tick(1);
        send = 1'b0;
        for (i = 0; i < 10; i++) begin
            tick((i == 0) ? 7 : 8);
            prev = exp_bits.pop_front();
            `CHK(rx_core, prev)
        end
        tick(20);
        close_out();
    end
endmodule : testbench
`default_nettype wire
